/* File: t1lic_pkg.sv */
package t1lic_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int NREG = 9;
    localparam int I_TPL_CTL = 0;
    localparam int I_TPL_DATA = 1;
    localparam int I_RJA = 2;
    localparam int I_RXP = 3;
    localparam int I_RXEQ = 4;
    localparam int I_RXSL = 5;
    localparam int I_LOOP = 6;
    localparam int I_LOSA = 7;
    localparam int I_EXZ = 8;
    localparam logic [NREG-1:0][7:0] REG_OFS = {
        8'h31, 8'h2c, 8'h2b, 8'h2a, 8'h29, 8'h28, 8'h27, 8'h26, 8'h25};
    localparam logic [NREG-1:0][7:0] REG_MASK = {
        8'h5f, 8'h07, 8'h77, 8'h3f, 8'h5f, 8'h11, 8'h3f, 8'h7f, 8'hff};
    localparam logic [NREG-1:0][7:0] REG_RST = {
        8'h00, 8'h00, 8'h00, 8'h18, 8'h15, 8'h00, 8'h00, 8'h00, 8'h00};

    // ****************************************
    // field positions
    // ****************************************
    localparam int B_SAMP = 0;
    localparam int B_UI = 4;
    localparam int B_TPL_RW = 6;
    localparam int B_TPL_EN = 7;
    localparam int B_JBW = 0;
    localparam int B_JDP = 1;
    localparam int B_JEN = 3;
    localparam int B_JLIM = 4;
    localparam int B_JMODE = 5;
    localparam int B_RMD = 0;
    localparam int B_ROFF = 4;
    localparam int B_LOSTHR = 0;
    localparam int B_EQ = 6;
    localparam int B_MG = 0;
    localparam int B_UPDW = 2;
    localparam int B_SLICE = 4;
    localparam int B_LOOP_LO = 0;
    localparam int B_LOOP_HI = 4;
    localparam int B_TX_ALL_ONES_ON_LOSS = 0;
    localparam int B_RAISE = 1;
    localparam int B_LAC = 2;
    localparam int B_CNTTRF = 0;
    localparam int B_CNTMD = 1;
    localparam int B_EXZEN = 2;
    localparam int B_EXZDEF = 4;
    localparam int B_BPV = 6;

    // ****************************************
    // line constants
    // ****************************************
    localparam logic [10:0] LOS_DECL_T = 11'd175;
    localparam logic [10:0] LOS_DECL_I = 11'd1544;
    localparam logic [6:0] MARK_WIN_LAST = 7'd127;
    localparam logic [7:0] MARK_MIN = 8'd16;
    localparam logic [6:0] ZRUN_MAX = 7'd100;
    localparam logic [6:0] RUN_SAT = 7'h7f;
    localparam logic [6:0] EXZ_AMI_ANSI = 7'd15;
    localparam logic [6:0] EXZ_AMI_FCC = 7'd80;
    localparam logic [6:0] EXZ_B8ZS = 7'd7;
    localparam logic [1:0] EXZ_EN_CODE = 2'b01;
    localparam logic [4:0] LOS_THR_MAX = 5'd22;
    localparam logic [1:0] MG_22DB = 2'b01;
    localparam logic [6:0] SLICE_BASE = 7'd40;
    localparam logic [6:0] SLICE_STEP = 7'd10;
    localparam logic [8:0] PEAK_BASE = 9'd32;
    localparam logic [1:0] DP_128 = 2'b00;
    localparam logic [1:0] DP_64 = 2'b01;
    localparam logic [7:0] DEPTH_128 = 8'd128;
    localparam logic [7:0] DEPTH_64 = 8'd64;
    localparam logic [7:0] DEPTH_32 = 8'd32;
    localparam logic [2:0] MARGIN_128 = 3'd4;
    localparam logic [2:0] MARGIN_64 = 3'd3;
    localparam logic [2:0] MARGIN_32 = 3'd2;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [1:0] tpl_unit;
        logic [3:0] tpl_sample;
        logic tpl_en;
        logic tpl_read;
        logic [6:0] tpl_wvalue;
        logic ja_en;
        logic ja_bw_low;
        logic [7:0] ja_depth;
        logic [2:0] ja_margin;
        logic rx_power_off;
        logic rx_ami;
        logic equalizer_enable;
        logic [4:0] los_thr;
        logic [6:0] slicer_pct;
        logic [8:0] peak_window;
        logic mon_gain_22db;
        logic [5:0] loops;
    } t1lic_ctrl_t;

    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic [7:0] rdata;
        logic [6:0] tpl_rd;
        logic [6:0] jit;
        logic los;
        logic [10:0] below;
        logic [6:0] win;
        logic [7:0] marks;
        logic [6:0] zrun;
        logic zlong;
        logic [6:0] exz_run;
        logic [15:0] exz_cnt;
        logic [15:0] exz_res;
        logic bpv_d;
        logic trf_d;
        logic bpv_p;
        logic rx_out;
    } t1lic_state_t;
endpackage

/* File: t1lic_top.sv */
`timescale 1ns/1ps
module t1lic_top
    import t1lic_pkg::*;
(
    // clock and reset
    input logic sys_clk,
    input logic resetn,
    // register port
    input logic [7:0] reg_addr,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // receive line side
    input logic rx_bit_valid,
    input logic rx_bit,
    input logic rx_below_thresh,
    input logic rx_above_clear,
    input logic rx_jitter_sample,
    input logic [6:0] rx_jitter_interval,
    input logic one_sec_tick,
    // results
    output logic rx_data_out,
    output logic signal_loss,
    output logic tx_all_ones,
    output logic tx_violation_pulse,
    output logic excess_zero_error,
    output logic [6:0] rx_jitter_value,
    output logic [15:0] excess_zero_result,
    output logic [6:0] template_read_value,
    output logic ja_widen,
    // analog and path controls
    output t1lic_ctrl_t ctrl
);
    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic [6:0] exz_limit(input logic ami,
                                             input logic fcc);
        exz_limit = !ami ? EXZ_B8ZS : (fcc ? EXZ_AMI_FCC : EXZ_AMI_ANSI);
    endfunction

    function automatic logic [7:0] ja_depth(input logic [1:0] dp);
        ja_depth = (dp == DP_128) ? DEPTH_128 :
                   (dp == DP_64) ? DEPTH_64 : DEPTH_32;
    endfunction

    function automatic logic [2:0] ja_margin(input logic [1:0] dp);
        ja_margin = (dp == DP_128) ? MARGIN_128 :
                    (dp == DP_64) ? MARGIN_64 : MARGIN_32;
    endfunction

    localparam t1lic_state_t ST_RST = '{regs: REG_RST, default: '0};

    t1lic_state_t s;
    t1lic_state_t next_s;
    logic [6:0] tpl_ram [64];
    logic [5:0] tpl_addr;
    logic tpl_en;
    logic tpl_rw;
    logic [10:0] los_lim;
    logic los_crit;
    logic exz_inc;
    logic trf_rise;
    logic cnt_copy;
    logic [7:0] depth;
    logic [2:0] margin;
    logic [7:0] ival;

    assign tpl_addr = {s.regs[I_TPL_CTL][B_UI +: 2],
                       s.regs[I_TPL_CTL][B_SAMP +: 4]};
    assign tpl_en = s.regs[I_TPL_CTL][B_TPL_EN];
    assign tpl_rw = s.regs[I_TPL_CTL][B_TPL_RW];
    assign los_crit = s.regs[I_LOSA][B_LAC];
    assign los_lim = los_crit ? LOS_DECL_I : LOS_DECL_T;

    // zero that makes the run exceed the limit
    assign excess_zero_error = rx_bit_valid && !rx_bit &&
        s.exz_run == exz_limit(s.regs[I_RXP][B_RMD],
                               s.regs[I_EXZ][B_EXZDEF]);
    assign exz_inc = excess_zero_error &&
        s.regs[I_EXZ][B_EXZEN +: 2] == EXZ_EN_CODE;
    assign trf_rise = !s.regs[I_EXZ][B_CNTMD] &&
        s.regs[I_EXZ][B_CNTTRF] && !s.trf_d;
    assign cnt_copy = s.regs[I_EXZ][B_CNTMD] ? one_sec_tick : trf_rise;

    assign depth = ja_depth(s.regs[I_RJA][B_JDP +: 2]);
    assign margin = ja_margin(s.regs[I_RJA][B_JDP +: 2]);
    assign ival = {1'b0, rx_jitter_interval};
    assign ja_widen = s.regs[I_RJA][B_JEN] && s.regs[I_RJA][B_JLIM] &&
        (ival < {5'h00, margin} || ival > depth - {5'h00, margin});

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        for (int i = 0; i < NREG; i++) begin
            if (reg_wr && reg_addr == REG_OFS[i]) begin
                next_s.regs[i] = reg_wdata & REG_MASK[i];
            end
        end
        if (reg_rd) begin
            next_s.rdata = 8'h00;
            for (int i = 0; i < NREG; i++) begin
                if (reg_addr == REG_OFS[i]) begin
                    next_s.rdata = s.regs[i];
                end
            end
        end
        if (tpl_en && tpl_rw) begin
            next_s.tpl_rd = tpl_ram[tpl_addr];
        end
        if (rx_jitter_sample) begin
            if (s.regs[I_RJA][B_JMODE] && s.jit > rx_jitter_interval) begin
                next_s.jit = s.jit;
            end else begin
                next_s.jit = rx_jitter_interval;
            end
        end
        if (rx_bit_valid) begin
            if (!rx_below_thresh) begin
                next_s.below = 11'h000;
            end else if (s.below != los_lim) begin
                next_s.below = s.below + 11'h001;
            end
            if (rx_below_thresh && s.below + 11'h001 == los_lim) begin
                next_s.los = 1'b1;
            end
            next_s.win = s.win + 7'h01;
            next_s.marks = s.marks + {7'h00, rx_bit};
            if (rx_bit) begin
                next_s.zrun = 7'h00;
            end else if (s.zrun != RUN_SAT) begin
                next_s.zrun = s.zrun + 7'h01;
            end
            if (next_s.zrun >= ZRUN_MAX) begin
                next_s.zlong = 1'b1;
            end
            if (s.win == MARK_WIN_LAST) begin
                if (s.los && rx_above_clear && !rx_below_thresh &&
                    next_s.marks >= MARK_MIN && !next_s.zlong) begin
                    next_s.los = 1'b0;
                end
                next_s.marks = 8'h00;
                next_s.zlong = 1'b0;
            end
            // zero run for excess zero check
            if (rx_bit) begin
                next_s.exz_run = 7'h00;
            end else if (s.exz_run != RUN_SAT) begin
                next_s.exz_run = s.exz_run + 7'h01;
            end
            next_s.rx_out = (s.regs[I_LOSA][B_RAISE] && s.los) || rx_bit;
        end
        if (cnt_copy) begin
            next_s.exz_res = s.exz_cnt;
            next_s.exz_cnt = {15'h0000, exz_inc};
        end else if (exz_inc) begin
            next_s.exz_cnt = s.exz_cnt + 16'h0001;
        end
        next_s.trf_d = s.regs[I_EXZ][B_CNTTRF];
        next_s.bpv_d = s.regs[I_EXZ][B_BPV];
        next_s.bpv_p = s.regs[I_EXZ][B_BPV] && !s.bpv_d;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    // template store only while enabled for write
    always_ff @(posedge sys_clk) begin
        if (tpl_en && !tpl_rw) begin
            tpl_ram[tpl_addr] <= s.regs[I_TPL_DATA][6:0];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata = s.rdata;
    assign rx_data_out = s.rx_out;
    assign signal_loss = s.los;
    // transmit all ones on receive loss
    assign tx_all_ones = s.los && s.regs[I_LOSA][B_TX_ALL_ONES_ON_LOSS];
    assign tx_violation_pulse = s.bpv_p;
    assign rx_jitter_value = s.jit;
    assign excess_zero_result = s.exz_res;
    assign template_read_value = s.tpl_rd;

    always_comb begin
        ctrl.tpl_unit = s.regs[I_TPL_CTL][B_UI +: 2];
        ctrl.tpl_sample = s.regs[I_TPL_CTL][B_SAMP +: 4];
        ctrl.tpl_en = tpl_en;
        ctrl.tpl_read = tpl_rw;
        ctrl.tpl_wvalue = s.regs[I_TPL_DATA][6:0];
        ctrl.ja_en = s.regs[I_RJA][B_JEN];
        ctrl.ja_bw_low = s.regs[I_RJA][B_JBW];
        ctrl.ja_depth = depth;
        ctrl.ja_margin = margin;
        ctrl.rx_power_off = s.regs[I_RXP][B_ROFF];
        ctrl.rx_ami = s.regs[I_RXP][B_RMD];
        ctrl.equalizer_enable = s.regs[I_RXEQ][B_EQ];
        // threshold capped, unused in short haul
        if (!s.regs[I_RXEQ][B_EQ]) begin
            ctrl.los_thr = 5'h00;
        end else if (s.regs[I_RXEQ][B_LOSTHR +: 5] > LOS_THR_MAX) begin
            ctrl.los_thr = LOS_THR_MAX;
        end else begin
            ctrl.los_thr = s.regs[I_RXEQ][B_LOSTHR +: 5];
        end
        ctrl.slicer_pct = SLICE_BASE +
            7'(SLICE_STEP * {5'h00, s.regs[I_RXSL][B_SLICE +: 2]});
        ctrl.peak_window = PEAK_BASE << s.regs[I_RXSL][B_UPDW +: 2];
        ctrl.mon_gain_22db = s.regs[I_RXSL][B_MG +: 2] == MG_22DB;
        ctrl.loops = {s.regs[I_LOOP][B_LOOP_HI +: 3],
                      s.regs[I_LOOP][B_LOOP_LO +: 3]};
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    property p_bpv_once;
        $rose(s.regs[I_EXZ][B_BPV]) |=> tx_violation_pulse ##1
            !tx_violation_pulse;
    endproperty
    a_bpv_once: assert property (p_bpv_once)
        else $error("violation pulse not single");

    property p_rx_ones;
        (rx_bit_valid && s.los && s.regs[I_LOSA][B_RAISE]) |=> rx_data_out;
    endproperty
    a_rx_ones: assert property (p_rx_ones)
        else $error("receive all ones missing");

    property p_tx_ones;
        s.los && s.regs[I_LOSA][B_TX_ALL_ONES_ON_LOSS] |-> tx_all_ones;
    endproperty
    a_tx_ones: assert property (p_tx_ones)
        else $error("transmit all ones missing");

    property p_los_t;
        $rose(s.los) && !$past(los_crit) |->
            $past(s.below) == LOS_DECL_T - 11'h001;
    endproperty
    a_los_t: assert property (p_los_t)
        else $error("loss declared at wrong count");

    property p_los_i;
        $rose(s.los) && $past(los_crit) |->
            $past(s.below) == LOS_DECL_I - 11'h001;
    endproperty
    a_los_i: assert property (p_los_i)
        else $error("long loss declared at wrong count");

    property p_jit_cur;
        rx_jitter_sample && !s.regs[I_RJA][B_JMODE] |=>
            rx_jitter_value == $past(rx_jitter_interval);
    endproperty
    a_jit_cur: assert property (p_jit_cur)
        else $error("jitter interval not stored");

    property p_cnt_hold;
        !exz_inc && !cnt_copy |=> $stable(s.exz_cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold)
        else $error("counter moved without enabled error");

    property p_copy;
        cnt_copy |=> excess_zero_result == $past(s.exz_cnt);
    endproperty
    a_copy: assert property (p_copy)
        else $error("counter not transferred");

    property p_rsvd;
        reg_rd && reg_addr == REG_OFS[I_RXP] |=>
            (reg_rdata & ~REG_MASK[I_RXP]) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");

    property p_jit_peak;
        rx_jitter_sample && s.regs[I_RJA][B_JMODE] |=>
            rx_jitter_value >= $past(rx_jitter_interval) &&
            rx_jitter_value >= $past(rx_jitter_value);
    endproperty
    a_jit_peak: assert property (p_jit_peak)
        else $error("jitter peak not kept");

    property p_los_clr;
        $fell(s.los) |-> $past(rx_bit_valid) && $past(rx_above_clear) &&
            $past(s.win) == MARK_WIN_LAST;
    endproperty
    a_los_clr: assert property (p_los_clr)
        else $error("loss cleared outside window end");

    property p_rx_pass;
        rx_bit_valid && !(s.los && s.regs[I_LOSA][B_RAISE]) |=>
            rx_data_out == $past(rx_bit);
    endproperty
    a_rx_pass: assert property (p_rx_pass)
        else $error("receive data altered without loss");

    property p_exz_single;
        excess_zero_error |=> !excess_zero_error;
    endproperty
    a_exz_single: assert property (p_exz_single)
        else $error("excess zero flagged twice in one run");

    property p_bpv_quiet;
        !$rose(s.regs[I_EXZ][B_BPV]) |=> !tx_violation_pulse;
    endproperty
    a_bpv_quiet: assert property (p_bpv_quiet)
        else $error("violation pulse without inject edge");

    c_los: cover property ($rose(s.los));
    c_los_clr: cover property ($fell(s.los));
    c_bpv: cover property (tx_violation_pulse);
    c_copy: cover property (cnt_copy && s.exz_cnt != 16'h0000);
    c_widen: cover property (ja_widen && rx_jitter_sample);
endmodule

/* File: t1lic_line_model.sv */
`timescale 1ns/1ps
module t1lic_line_model (
    // clock
    input logic sys_clk,
    // line toward the receiver
    output logic rx_bit_valid,
    output logic rx_bit,
    output logic rx_below_thresh,
    output logic rx_above_clear
);
    initial begin
        rx_bit_valid = 1'b0;
        rx_bit = 1'b0;
        rx_below_thresh = 1'b0;
        rx_above_clear = 1'b0;
    end

    // ****************************************
    // one bit every two clocks
    // ****************************************
    // pat 0 zeros, 1 marks, 2 alternating
    task automatic send(input int n, input int pat, input logic below,
                        input logic above);
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            rx_bit_valid = 1'b1;
            rx_bit = (pat == 2) ? i[0] : pat[0];
            rx_below_thresh = below;
            rx_above_clear = above;
            @(negedge sys_clk);
            rx_bit_valid = 1'b0;
            // no stale level between bits
            rx_bit = ~rx_bit;
            rx_below_thresh = ~rx_below_thresh;
            rx_above_clear = ~rx_above_clear;
        end
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) chk(g, e)
module tb
    import t1lic_pkg::*;
;
    logic sys_clk, resetn, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic rx_bit_valid, rx_bit, rx_below_thresh, rx_above_clear;
    logic rx_jitter_sample, one_sec_tick;
    logic [6:0] rx_jitter_interval, rx_jitter_value, template_read_value;
    logic rx_data_out, signal_loss, tx_all_ones, tx_violation_pulse;
    logic excess_zero_error, ja_widen;
    logic [15:0] excess_zero_result;
    t1lic_ctrl_t ctrl;
    int err_total = 0;
    int num_checks = 0;
    int exz_seen = 0;
    int bpv_seen = 0;

    t1lic_top dut (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit), .rx_below_thresh(rx_below_thresh),
        .rx_above_clear(rx_above_clear),
        .rx_jitter_sample(rx_jitter_sample),
        .rx_jitter_interval(rx_jitter_interval),
        .one_sec_tick(one_sec_tick), .rx_data_out(rx_data_out),
        .signal_loss(signal_loss), .tx_all_ones(tx_all_ones),
        .tx_violation_pulse(tx_violation_pulse),
        .excess_zero_error(excess_zero_error),
        .rx_jitter_value(rx_jitter_value),
        .excess_zero_result(excess_zero_result),
        .template_read_value(template_read_value),
        .ja_widen(ja_widen), .ctrl(ctrl)
    );

    t1lic_line_model line (
        .sys_clk(sys_clk), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .rx_below_thresh(rx_below_thresh), .rx_above_clear(rx_above_clear)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ****************************************
    // event counters
    // ****************************************
    always @(posedge sys_clk) begin
        if (excess_zero_error === 1'b1) exz_seen++;
        if (tx_violation_pulse === 1'b1) bpv_seen++;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        `CHK(reg_rdata, e);
    endtask

    task automatic jit(input logic [6:0] v);
        @(negedge sys_clk);
        rx_jitter_sample = 1'b1;
        rx_jitter_interval = v;
        @(negedge sys_clk);
        rx_jitter_sample = 1'b0;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        logic [7:0] ofs[9] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
                               8'h2a, 8'h2b, 8'h2c, 8'h31};
        logic [7:0] msk[9] = '{8'hff, 8'h7f, 8'h3f, 8'h11, 8'h5f,
                               8'h3f, 8'h77, 8'h07, 8'h5f};
        logic [7:0] d;
        for (int i = 8'h25; i <= 8'h31; i++) begin
            d = (i == 8'h29) ? 8'h15 : (i == 8'h2a) ? 8'h18 : 8'h00;
            rd_chk(i[7:0], d);
        end
        for (int i = 0; i < 9; i++) begin
            d = (ofs[i] == 8'h2a) ? 8'hfd : 8'hff;
            wr(ofs[i], d);
            rd_chk(ofs[i], msk[i] & d);
            wr(ofs[i], 8'h00);
        end
        wr(8'h2d, 8'hff);
        rd_chk(8'h2d, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_decode();
        int dep[4] = '{128, 64, 32, 32};
        int mar[4] = '{4, 3, 2, 2};
        logic [7:0] lb[6] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
        for (int i = 0; i < 4; i++) begin
            wr(8'h2a, {2'b00, i[1:0], i[1:0], 1'b0, i == 1});
            `CHK(ctrl.slicer_pct, 40 + 10 * i);
            `CHK(ctrl.peak_window, 32 << i);
            `CHK(ctrl.mon_gain_22db, i == 1);
            wr(8'h27, {5'b00000, i[1:0], 1'b0});
            `CHK(ctrl.ja_depth, dep[i]);
            `CHK(ctrl.ja_margin, mar[i]);
        end
        wr(8'h27, 8'h09);
        `CHK(ctrl.ja_en, 1);
        `CHK(ctrl.ja_bw_low, 1);
        for (int k = 0; k < 6; k++) begin
            wr(8'h2b, lb[k]);
            `CHK(ctrl.loops, 6'h20 >> k);
        end
        wr(8'h28, 8'h11);
        `CHK(ctrl.rx_power_off, 1);
        `CHK(ctrl.rx_ami, 1);
        wr(8'h28, 8'h00);
        `CHK(ctrl.rx_power_off, 0);
        wr(8'h29, 8'h05);
        `CHK(ctrl.los_thr, 0);
        wr(8'h29, 8'h45);
        `CHK(ctrl.equalizer_enable, 1);
        `CHK(ctrl.los_thr, 5);
        wr(8'h29, 8'h5f);
        `CHK(ctrl.los_thr, 22);
        $display("test decode done");
    endtask

    task automatic t_tpl();
        wr(8'h26, 8'h5a);
        wr(8'h25, 8'ha9);
        wr(8'h25, 8'h29);
        wr(8'h26, 8'h11);
        wr(8'h25, 8'h99);
        wr(8'h25, 8'h19);
        wr(8'h25, 8'he9);
        repeat (2) @(negedge sys_clk);
        `CHK(template_read_value, 7'h5a);
        wr(8'h25, 8'hd9);
        repeat (2) @(negedge sys_clk);
        `CHK(template_read_value, 7'h11);
        `CHK(ctrl.tpl_unit, 1);
        `CHK(ctrl.tpl_sample, 9);
        `CHK(ctrl.tpl_read, 1);
        `CHK(ctrl.tpl_en, 1);
        `CHK(ctrl.tpl_wvalue, 7'h11);
        $display("test template done");
    endtask

    task automatic t_jit();
        int iv[5] = '{1, 16, 31, 126, 100};
        int ex[5] = '{1, 0, 1, 1, 0};
        wr(8'h27, 8'h00);
        jit(7'd50);
        jit(7'd20);
        `CHK(rx_jitter_value, 20);
        wr(8'h27, 8'h20);
        jit(7'd30);
        jit(7'd10);
        `CHK(rx_jitter_value, 30);
        for (int i = 0; i < 5; i++) begin
            wr(8'h27, (i < 3) ? 8'h1c : 8'h18);
            jit(iv[i][6:0]);
            `CHK(ja_widen, ex[i]);
        end
        wr(8'h27, 8'h0c);
        jit(7'd1);
        `CHK(ja_widen, 0);
        $display("test jitter done");
    endtask

    task automatic t_bpv();
        bpv_seen = 0;
        wr(8'h31, 8'h40);
        wr(8'h31, 8'h40);
        repeat (4) @(negedge sys_clk);
        `CHK(bpv_seen, 1);
        wr(8'h31, 8'h00);
        wr(8'h31, 8'h40);
        repeat (4) @(negedge sys_clk);
        `CHK(bpv_seen, 2);
        $display("test violation done");
    endtask

    task automatic t_loss();
        int n;
        for (int c = 0; c < 2; c++) begin
            n = c ? 1544 : 175;
            wr(8'h2c, {5'b00000, c[0], ~c[0], ~c[0]});
            line.send(n - 1, 0, 1'b1, 1'b0);
            `CHK(signal_loss, 0);
            line.send(1, 0, 1'b1, 1'b0);
            `CHK(signal_loss, 1);
            line.send(1, 0, 1'b1, 1'b0);
            `CHK(rx_data_out, c == 0);
            `CHK(tx_all_ones, c == 0);
            line.send(256, 2, 1'b0, 1'b1);
            `CHK(signal_loss, 0);
            line.send(1, 0, 1'b0, 1'b1);
            `CHK(rx_data_out, 0);
            `CHK(tx_all_ones, 0);
        end
        $display("test loss done");
    endtask

    task automatic t_exz();
        logic am[3] = '{1'b0, 1'b1, 1'b1};
        logic df[3] = '{1'b0, 1'b0, 1'b1};
        int lim[3] = '{7, 15, 80};
        wr(8'h31, 8'h04);
        wr(8'h31, 8'h05);
        wr(8'h31, 8'h04);
        exz_seen = 0;
        for (int k = 0; k < 3; k++) begin
            wr(8'h28, {7'b0000000, am[k]});
            wr(8'h31, {3'b000, df[k], 4'b0100});
            line.send(1, 1, 1'b0, 1'b1);
            line.send(lim[k], 0, 1'b0, 1'b1);
            `CHK(exz_seen, k);
            line.send(1, 0, 1'b0, 1'b1);
            `CHK(exz_seen, k + 1);
        end
        line.send(1, 1, 1'b0, 1'b1);
        wr(8'h31, 8'h15);
        repeat (3) @(negedge sys_clk);
        `CHK(excess_zero_result, 3);
        line.send(82, 0, 1'b0, 1'b1);
        wr(8'h31, 8'h15);
        repeat (3) @(negedge sys_clk);
        `CHK(excess_zero_result, 3);
        wr(8'h31, 8'h14);
        wr(8'h31, 8'h15);
        repeat (3) @(negedge sys_clk);
        `CHK(excess_zero_result, 1);
        wr(8'h31, 8'h18);
        line.send(1, 1, 1'b0, 1'b1);
        line.send(82, 0, 1'b0, 1'b1);
        wr(8'h31, 8'h19);
        repeat (3) @(negedge sys_clk);
        `CHK(excess_zero_result, 0);
        wr(8'h31, 8'h16);
        line.send(1, 1, 1'b0, 1'b1);
        line.send(82, 0, 1'b0, 1'b1);
        @(negedge sys_clk);
        one_sec_tick = 1'b1;
        @(negedge sys_clk);
        one_sec_tick = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(excess_zero_result, 1);
        $display("test excess zero done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rx_jitter_sample = 1'b0;
        rx_jitter_interval = 7'h00;
        one_sec_tick = 1'b0;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        t_regs();
        t_decode();
        t_tpl();
        t_jit();
        t_bpv();
        t_loss();
        t_exz();
        print_verdict();
    end
endmodule
